// file: rtl/cfe_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module cfe_ctrl (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic [cfe_pkg::ADDR_W-1:0] avm_address_in,
	input wire logic avm_read_in,
	input wire logic avm_write_in,
	input wire logic [3:0] avm_byteenable_in,
	input wire logic [cfe_pkg::DATA_W-1:0] avm_writedata_in,
	output logic [cfe_pkg::DATA_W-1:0] avm_readdata_out,
	output logic avm_waitrequest_out,
	input wire cfe_pkg::cfe_link_type link_in,
	output logic tx_req_out,
	output logic [1:0] tx_buf_out,
	output logic tx_corrupt_out,
	output logic bus_integ_out,
	output logic rx_store_bad_out
);
	import cfe_pkg::*;

	typedef struct packed {
		logic bus_wait;
		logic [DATA_W-1:0] rdata;
		logic init;
		logic clock_stop_request;
		logic no_auto_retx_bit;
		logic cce;
		logic clock_stop_ack;
		logic [7:0] ram_wd;
		logic [IRQ_W-1:0] irq;
		logic [NUM_BUF-1:0] pend;
		logic [NUM_BUF-1:0] cancel;
		logic [1:0] evt_type;
		logic [1:0] evt_buf;
		logic [1:0] last_buf;
		logic last_valid;
		logic in_im;
		logic after_rx;
		logic [1:0] im_cnt;
		logic req_window;
		cfe_integ_type integ;
		logic [3:0] integ_cnt;
		logic fdf_q;
		logic discard;
		logic pex_rx;
		logic pex_tx;
		logic init_in_rx;
		logic init_arm;
		logic [7:0] wd_cnt;
		logic ram_wait;
		logic rx_act_q;
		logic tx_act_q;
		logic store_bad;
		logic tx_corrupt;
		logic tx_req;
		logic [1:0] tx_buf;
	} cfe_state_type;

	cfe_state_type st;
	cfe_state_type next_st;
	logic [1:0] node;
	logic wr_go;
	logic [1:0] req_idx;

	function automatic logic hit(input logic [ADDR_W-1:0] a,
			input logic [ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	function automatic logic [1:0] first_pend(input logic [NUM_BUF-1:0] p);
		first_pend = 2'h0;
		for (int i = NUM_BUF - 1; i >= 0; i--) begin
			if (p[i]) begin
				first_pend = i[1:0];
			end
		end
	endfunction : first_pend

	always_comb begin
		next_st = st;
		req_idx = avm_writedata_in[1:0];
		// integration counts as sync, so requests are never taken as receiver
		if (st.integ != INTEG_RUN) begin
			node = NODE_SYNC;
		end else if (link_in.tx_active) begin
			node = NODE_TX;
		end else if (link_in.rx_active || st.after_rx) begin
			node = NODE_RX;
		end else begin
			node = NODE_IDLE;
		end
		// one wait cycle per access; the write lands when wait drops
		next_st.bus_wait = !((avm_read_in || avm_write_in) && st.bus_wait);
		wr_go = avm_write_in && !st.bus_wait && avm_byteenable_in[0];
		if (avm_read_in && st.bus_wait) begin
			next_st.rdata = '0;
			case (avm_address_in)
				OFS_CTRL: begin
					next_st.rdata[CTRL_INIT] = st.init;
					next_st.rdata[CTRL_CSR] = st.clock_stop_request;
					next_st.rdata[CTRL_DAR] = st.no_auto_retx_bit;
					next_st.rdata[CTRL_CCE] = st.cce;
				end
				OFS_STAT: begin
					next_st.rdata[STAT_CSA] = st.clock_stop_ack;
					next_st.rdata[STAT_NODE +: 2] = node;
					next_st.rdata[STAT_INTEG] = (st.integ != INTEG_RUN);
					next_st.rdata[STAT_CANCEL +: NUM_BUF] = st.cancel;
				end
				OFS_IRQF: next_st.rdata[IRQ_W-1:0] = st.irq;
				OFS_ERR: begin
					next_st.rdata[7:0] = link_in.rx_error_count;
					next_st.rdata[ERR_EP] = link_in.ep;
				end
				OFS_RAMWD: next_st.rdata[7:0] = st.ram_wd;
				OFS_TXREQ: next_st.rdata[NUM_BUF-1:0] = st.pend;
				OFS_TXEVT: begin
					next_st.rdata[1:0] = st.evt_type;
					next_st.rdata[EVT_BUF +: 2] = st.evt_buf;
				end
				default: next_st.rdata = '0;
			endcase
		end

		// software writes first; hardware events below override them
		if (wr_go && hit(avm_address_in, OFS_CTRL)) begin
			next_st.init = avm_writedata_in[CTRL_INIT];
			next_st.clock_stop_request = avm_writedata_in[CTRL_CSR];
			next_st.no_auto_retx_bit = avm_writedata_in[CTRL_DAR];
			next_st.cce = avm_writedata_in[CTRL_CCE];
			if (avm_writedata_in[CTRL_INIT] && !st.init && link_in.rx_active) begin
				next_st.init_in_rx = 1'b1;
			end
			if (!avm_writedata_in[CTRL_INIT] && st.init && st.init_in_rx) begin
				next_st.init_in_rx = 1'b0;
				next_st.init_arm = 1'b1;
			end
		end
		if (wr_go && hit(avm_address_in, OFS_IRQF)) begin
			next_st.irq = st.irq & ~avm_writedata_in[IRQ_W-1:0];
		end
		if (wr_go && hit(avm_address_in, OFS_RAMWD)) begin
			next_st.ram_wd = avm_writedata_in[7:0];
		end
		if (wr_go && hit(avm_address_in, OFS_TXREQ)) begin
			if (st.no_auto_retx_bit && st.last_valid && req_idx == st.last_buf) begin
				next_st.cancel[req_idx] = 1'b1;
			end else begin
				next_st.pend[req_idx] = 1'b1;
				next_st.cancel[req_idx] = 1'b0;
				// a request taken at the third sample is cleared again below
				if (node == NODE_RX && st.pend == '0) begin
					next_st.req_window = 1'b1;
				end
			end
		end

		// clock stop waits for a quiet bus, so no frame is cut off
		if (st.clock_stop_request && !link_in.rx_active && !link_in.tx_active) begin
			next_st.init = 1'b1;
		end
		next_st.clock_stop_ack = next_st.clock_stop_request && next_st.init
				&& (st.clock_stop_ack || (!link_in.rx_active && !link_in.tx_active));

		if (link_in.sample_pt) begin
			if (link_in.at_fdf) begin
				next_st.fdf_q = link_in.bus_bit;
			end
			if (link_in.at_res && link_in.bus_bit && st.fdf_q) begin
				next_st.integ = INTEG_WAIT_DOM;
				next_st.irq[IRQ_PEX] = 1'b1;
				next_st.discard = 1'b1;
				next_st.pex_rx = 1'b1;
				next_st.pex_tx = 1'b1;
			end else begin
				case (st.integ)
					INTEG_WAIT_DOM: begin
						if (!link_in.bus_bit) begin
							next_st.integ = INTEG_COUNT;
							next_st.integ_cnt = '0;
						end
					end
					INTEG_COUNT: begin
						if (!link_in.bus_bit) begin
							next_st.integ_cnt = '0;
						end else if (st.integ_cnt == INTEG_LAST) begin
							next_st.integ = INTEG_RUN;
							next_st.discard = 1'b0;
						end else begin
							next_st.integ_cnt = st.integ_cnt + 4'h1;
						end
					end
					INTEG_RUN: next_st.integ = INTEG_RUN;
					default: next_st.integ = INTEG_RUN;
				endcase
			end
			if (st.in_im) begin
				next_st.im_cnt = st.im_cnt + 2'h1;
				if (st.im_cnt == IM_THIRD) begin
					next_st.in_im = 1'b0;
					next_st.after_rx = 1'b0;
					next_st.last_valid = 1'b0;
					next_st.req_window = 1'b0;
					if (st.req_window && !link_in.bus_bit) begin
						next_st.tx_corrupt = 1'b1;
					end
				end
			end
		end
		if (link_in.eof_last) begin
			next_st.in_im = 1'b1;
			next_st.im_cnt = '0;
			next_st.after_rx = link_in.rx_active;
		end

		if (link_in.rx_ok && link_in.eof_last && !st.discard
				&& st.integ == INTEG_RUN) begin
			case (link_in.rx_dest)
				DEST_DED: next_st.irq[IRQ_DRX] = 1'b1;
				DEST_F0: next_st.irq[IRQ_FIFO0_NEW_FLAG] = 1'b1;
				DEST_F1: next_st.irq[IRQ_FIFO1_NEW_FLAG] = 1'b1;
				default: next_st.irq[IRQ_DRX] = 1'b1;
			endcase
			if (st.init_arm || st.pex_rx) begin
				next_st.irq[IRQ_MSG_RAM_FAIL_FLAG] = 1'b1;
			end
			next_st.init_arm = 1'b0;
			next_st.pex_rx = 1'b0;
			next_st.store_bad = 1'b0;
		end
		if (link_in.rx_active && link_in.eof_last && link_in.ep
				&& link_in.rx_error_count == REC_PASSIVE) begin
			next_st.irq[IRQ_MSG_RAM_FAIL_FLAG] = 1'b1;
		end

		next_st.rx_act_q = link_in.rx_active;
		if (link_in.ram_gnt || !link_in.ram_req) begin
			next_st.ram_wait = 1'b0;
			next_st.wd_cnt = '0;
		end else begin
			next_st.ram_wait = 1'b1;
			if (st.wd_cnt != st.ram_wd) begin
				next_st.wd_cnt = st.wd_cnt + 8'h01;
			end else if (st.ram_wd != RAMWD_RST) begin
				next_st.irq[IRQ_WDI] = 1'b1;
			end
		end
		// a frame still unstored when the next starts is lost
		if (link_in.rx_active && !st.rx_act_q && st.ram_wait) begin
			next_st.irq[IRQ_MSG_RAM_FAIL_FLAG] = 1'b1;
			next_st.store_bad = 1'b1;
		end

		next_st.tx_act_q = link_in.tx_active;
		if (link_in.tx_active && !st.tx_act_q && st.pex_tx) begin
			next_st.tx_corrupt = 1'b1;
			next_st.pex_tx = 1'b0;
		end
		if (link_in.tx_ok) begin
			next_st.pend[st.tx_buf] = 1'b0;
			next_st.evt_type = EVT_TX;
			next_st.evt_buf = st.tx_buf;
			next_st.last_buf = st.tx_buf;
			next_st.last_valid = 1'b1;
			next_st.tx_corrupt = 1'b0;
			next_st.req_window = 1'b0;
		end else if (link_in.tx_lost || link_in.tx_err) begin
			next_st.tx_corrupt = 1'b0;
			next_st.req_window = 1'b0;
			if (st.no_auto_retx_bit) begin
				next_st.pend[st.tx_buf] = 1'b0;
				next_st.cancel[st.tx_buf] = 1'b1;
			end
		end
		next_st.tx_req = (next_st.pend != '0) && !next_st.init;
		next_st.tx_buf = first_pend(next_st.pend);
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= '0;
			st.bus_wait <= 1'b1;
			st.init <= 1'b1;
			st.integ <= INTEG_RUN;
			st.ram_wd <= RAMWD_RST;
		end else if (ce_in) begin
			st <= next_st;
		end
	end

	assign avm_readdata_out = st.rdata;
	assign avm_waitrequest_out = st.bus_wait;
	assign tx_req_out = st.tx_req;
	assign tx_buf_out = st.tx_buf;
	assign tx_corrupt_out = st.tx_corrupt;
	assign bus_integ_out = (st.integ != INTEG_RUN);
	assign rx_store_bad_out = st.store_bad;
endmodule : cfe_ctrl
`default_nettype wire

// file: shared/cfe_pkg.sv
package cfe_pkg;
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned NUM_BUF = 4;
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_STAT = 5'h04;
	localparam logic [4:0] OFS_IRQF = 5'h08;
	localparam logic [4:0] OFS_ERR = 5'h0C;
	localparam logic [4:0] OFS_RAMWD = 5'h10;
	localparam logic [4:0] OFS_TXREQ = 5'h14;
	localparam logic [4:0] OFS_TXEVT = 5'h18;
	localparam int unsigned CTRL_INIT = 0;
	localparam int unsigned CTRL_CSR = 1;
	localparam int unsigned CTRL_DAR = 2;
	localparam int unsigned CTRL_CCE = 3;
	localparam int unsigned STAT_CSA = 0;
	localparam int unsigned STAT_NODE = 1;
	localparam int unsigned STAT_INTEG = 3;
	localparam int unsigned STAT_CANCEL = 4;
	localparam int unsigned IRQ_MSG_RAM_FAIL_FLAG = 0;
	localparam int unsigned IRQ_WDI = 1;
	localparam int unsigned IRQ_DRX = 2;
	localparam int unsigned IRQ_FIFO0_NEW_FLAG = 3;
	localparam int unsigned IRQ_FIFO1_NEW_FLAG = 4;
	localparam int unsigned IRQ_PEX = 5;
	localparam int unsigned IRQ_W = 6;
	localparam int unsigned ERR_EP = 8;
	localparam int unsigned EVT_BUF = 4;
	localparam logic [1:0] NODE_SYNC = 2'h0;
	localparam logic [1:0] NODE_IDLE = 2'h1;
	localparam logic [1:0] NODE_RX = 2'h2;
	localparam logic [1:0] NODE_TX = 2'h3;
	localparam logic [1:0] EVT_TX = 2'h1;
	localparam logic [1:0] EVT_CANCEL = 2'h2;
	localparam logic [1:0] DEST_DED = 2'h0;
	localparam logic [1:0] DEST_F0 = 2'h1;
	localparam logic [1:0] DEST_F1 = 2'h2;
	localparam logic [7:0] REC_PASSIVE = 8'h7F;
	localparam logic [3:0] INTEG_LAST = 4'hA;
	localparam logic [1:0] IM_THIRD = 2'h2;
	localparam logic [7:0] RAMWD_RST = 8'h00;
	typedef enum logic [1:0] {
		INTEG_RUN = 2'b00,
		INTEG_WAIT_DOM = 2'b01,
		INTEG_COUNT = 2'b10
	} cfe_integ_type;
	typedef struct packed {
		logic sample_pt;
		logic bus_bit;
		logic at_fdf;
		logic at_res;
		logic eof_last;
		logic rx_active;
		logic tx_active;
		logic rx_ok;
		logic [1:0] rx_dest;
		logic ram_req;
		logic ram_gnt;
		logic tx_ok;
		logic tx_lost;
		logic tx_err;
		logic [7:0] rx_error_count;
		logic ep;
	} cfe_link_type;
endpackage : cfe_pkg

// file: verification/cfe_link_model.sv
`timescale 1ns/100ps
`default_nettype none
module cfe_link_model (
	input wire logic clk_in,
	output var cfe_pkg::cfe_link_type link_out
);
	import cfe_pkg::*;
	// idle bus is recessive; pulses kept apart from levels
	cfe_link_type lv = '{bus_bit: 1, default: 0};
	cfe_link_type pl = '0;
	assign link_out = lv | pl;
	task automatic lvl(input cfe_link_type v);
		lv <= v;
		@(posedge clk_in);
	endtask : lvl
	// four clocks a bit: short runs, still room for flags to land
	task automatic bitx(input logic b, input cfe_link_type f);
		cfe_link_type p;
		p = f;
		p.sample_pt = 1'b1;
		lv.bus_bit <= b;
		pl <= p;
		@(posedge clk_in);
		pl <= '0;
		repeat (3) @(posedge clk_in);
	endtask : bitx
endmodule : cfe_link_model
`default_nettype wire

// file: verification/cfe_ctrl_checker.sv
`timescale 1ns/100ps
`default_nettype none
module cfe_ctrl_checker (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic avm_read_in,
	input wire logic avm_write_in,
	input wire logic avm_waitrequest_out,
	input wire cfe_pkg::cfe_link_type link_in,
	input wire logic tx_corrupt_out,
	input wire logic bus_integ_out
);
	import cfe_pkg::*;
	logic fdf_rec, seen, pend, tx_prev;
	logic next_fdf_rec, next_seen, next_pend;
	logic [3:0] rcnt, next_rcnt;
	wire sp = link_in.sample_pt;
	wire dom = sp && !link_in.bus_bit;
	wire txr = link_in.tx_active && !tx_prev;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	always_comb begin
		next_fdf_rec = (sp && link_in.at_fdf) ? link_in.bus_bit : fdf_rec;
		next_seen = bus_integ_out && (seen || dom);
		next_rcnt = rcnt;
		if (!bus_integ_out || dom)
			next_rcnt = 4'h0;
		else if (sp && seen)
			next_rcnt = rcnt + 4'h1;
		// a send starting while still integrating is not taken as the first
		next_pend = bus_integ_out || (pend && !txr);
	end
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			{fdf_rec, seen, pend, tx_prev, rcnt} <= '0;
		end else begin
			{fdf_rec, seen, pend} <= {next_fdf_rec, next_seen, next_pend};
			{tx_prev, rcnt} <= {link_in.tx_active, next_rcnt};
		end
	end
	sequence pex_s;
		!bus_integ_out && sp && link_in.at_res && link_in.bus_bit && fdf_rec;
	endsequence
	sequence exit_s;
		bus_integ_out && seen && rcnt == 4'hA && sp && link_in.bus_bit;
	endsequence
	bus_answer_a: assert property ((avm_read_in || avm_write_in) &&
		avm_waitrequest_out |=> !avm_waitrequest_out) else $error("no answer");
	wait_pulse_a: assert property (!avm_waitrequest_out |=>
		avm_waitrequest_out) else $error("wait low too long");
	integ_enter_a: assert property (pex_s |=> bus_integ_out)
		else $error("no integration");
	integ_stay_a: assert property (
		bus_integ_out && dom |=> bus_integ_out)
		else $error("left on dominant");
	integ_exit_a: assert property (exit_s |=> !bus_integ_out)
		else $error("stuck in integration");
	integ_count_a: assert property (
		$fell(bus_integ_out) |-> rcnt == 4'hB)
		else $error("left early");
	corrupt_first_a: assert property (
		$rose(link_in.tx_active) && pend |=> tx_corrupt_out)
		else $error("first send not flagged");
	corrupt_clear_a: assert property (
		tx_corrupt_out && (link_in.tx_ok || link_in.tx_lost ||
		link_in.tx_err) |=> !tx_corrupt_out)
		else $error("stuck");
endmodule : cfe_ctrl_checker
`default_nettype wire

// file: verification/cfe_ctrl_test.sv
`timescale 1ns/100ps
`default_nettype none
module cfe_ctrl_test;
	import cfe_pkg::*;
	localparam cfe_link_type IDLE = '{bus_bit: 1, default: 0};
	localparam cfe_link_type RX = '{bus_bit: 1, rx_active: 1, default: 0};
	localparam cfe_link_type EOF = '{eof_last: 1, rx_ok: 1, default: 0};
	localparam cfe_link_type TXOK = '{tx_ok: 1, default: 0};
	localparam logic [31:0] ALL = '1;
	logic sys_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [ADDR_W-1:0] avm_address_in = '0;
	logic avm_read_in = 1'b0;
	logic avm_write_in = 1'b0;
	logic [3:0] avm_byteenable_in = 4'hF;
	logic [DATA_W-1:0] avm_writedata_in = '0;
	logic [DATA_W-1:0] avm_readdata_out, v;
	logic avm_waitrequest_out, tx_req_out, tx_corrupt_out;
	logic bus_integ_out, rx_store_bad_out;
	logic [1:0] tx_buf_out;
	cfe_link_type link_in, lk;
	int fails = 0;
	int n_compared = 0;
	int cyc = 0;
	wire [4:0] ob = {tx_buf_out, tx_req_out, tx_corrupt_out, bus_integ_out};
	always #20 sys_clk_in = ~sys_clk_in;
	cfe_link_model u_lk (.clk_in(sys_clk_in), .link_out(link_in));
	cfe_ctrl u_dut (.sys_clk_in, .rst_n_in, .ce_in(1'b1), .avm_address_in,
		.avm_read_in, .avm_write_in, .avm_byteenable_in, .avm_writedata_in,
		.avm_readdata_out, .avm_waitrequest_out, .link_in, .tx_req_out,
		.tx_buf_out, .tx_corrupt_out, .bus_integ_out, .rx_store_bad_out);
	task automatic chk(input string s, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
		avm_address_in <= a;
		avm_writedata_in <= d;
		avm_read_in <= !w;
		avm_write_in <= w;
		// request stands until the edge that samples waitrequest low
		do @(posedge sys_clk_in);
		while (avm_waitrequest_out !== 1'b0);
		v = avm_readdata_out;
		avm_read_in <= 1'b0;
		avm_write_in <= 1'b0;
		@(posedge sys_clk_in);
	endtask : acc
	task automatic rc(input logic [4:0] a, input logic [31:0] m, e, input string s);
		acc(1'b0, a, '0);
		chk(s, e, v & m);
	endtask : rc
	task automatic co(input logic [4:0] m, e, input string s);
		@(posedge sys_clk_in);
		@(negedge sys_clk_in);
		chk(s, {27'h0, e}, {27'h0, ob & m});
		@(posedge sys_clk_in);
	endtask : co
	task automatic frame(input cfe_link_type f);
		u_lk.lvl(f);
		u_lk.bitx(1'b1, EOF);
		f.rx_active = 1'b0;
		u_lk.lvl(f);
	endtask : frame
	task automatic clr;
		acc(1'b1, OFS_IRQF, 32'h3F);
	endtask : clr
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	always @(posedge sys_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			fails++;
			summarize();
		end
	end
	initial begin
		repeat (4) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		@(posedge sys_clk_in);
		rc(OFS_CTRL, ALL, 32'h1, "ctrl rst");
		rc(5'h1C, ALL, 32'h0, "unmapped");
		acc(1'b1, OFS_CTRL, 32'h0);
		for (int d = 0; d < 3; d++) begin
			lk = RX;
			lk.rx_dest = 2'(d);
			frame(lk);
			rc(OFS_IRQF, ALL, 32'h4 << d, "rx flag");
			clr();
		end
		u_lk.lvl(RX);
		acc(1'b1, OFS_CTRL, 32'h1);
		acc(1'b1, OFS_CTRL, 32'h0);
		frame(RX);
		rc(OFS_IRQF, ALL, 32'h5, "fail after hold");
		clr();
		acc(1'b1, OFS_CTRL, 32'h2);
		rc(OFS_CTRL, ALL, 32'h3, "hold by stop");
		rc(OFS_STAT, 32'h1, 32'h1, "stop ack");
		acc(1'b1, OFS_CTRL, 32'h1);
		rc(OFS_STAT, 32'h1, 32'h0, "ack drop");
		acc(1'b1, OFS_CTRL, 32'h0);
		lk = RX;
		lk.ep = 1'b1;
		lk.rx_error_count = REC_PASSIVE;
		frame(lk);
		rc(OFS_ERR, ALL, 32'h17F, "err count");
		rc(OFS_IRQF, ALL, 32'h5, "passive fail");
		clr();
		acc(1'b1, OFS_RAMWD, 32'h3);
		avm_byteenable_in <= 4'hE;
		acc(1'b1, OFS_RAMWD, 32'h9);
		avm_byteenable_in <= 4'hF;
		rc(OFS_RAMWD, ALL, 32'h3, "ramwd");
		u_lk.lvl('{bus_bit: 1, ram_req: 1, default: 0});
		repeat (5) @(posedge sys_clk_in);
		rc(OFS_IRQF, 32'h3, 32'h2, "watchdog");
		lk = '{bus_bit: 1, rx_active: 1, ram_req: 1, default: 0};
		u_lk.lvl(lk);
		@(negedge sys_clk_in);
		chk("store bad", 32'h1, {31'h0, rx_store_bad_out});
		@(posedge sys_clk_in);
		frame(lk);
		rc(OFS_IRQF, 32'h3, 32'h3, "late grant");
		u_lk.lvl(IDLE);
		clr();
		u_lk.lvl(RX);
		u_lk.bitx(1'b1, '{at_fdf: 1, default: 0});
		u_lk.bitx(1'b1, '{at_res: 1, default: 0});
		rc(OFS_STAT, 32'h8, 32'h8, "integ");
		u_lk.bitx(1'b1, EOF);
		repeat (11) u_lk.bitx(1'b1, '0);
		co(5'h1, 5'h1, "no dominant yet");
		u_lk.bitx(1'b0, '0);
		repeat (10) u_lk.bitx(1'b1, '0);
		co(5'h1, 5'h1, "ten recessive");
		u_lk.bitx(1'b1, '0);
		co(5'h1, 5'h0, "eleven recessive");
		u_lk.lvl(IDLE);
		rc(OFS_IRQF, ALL, 32'h20, "discarded");
		clr();
		frame(RX);
		rc(OFS_IRQF, ALL, 32'h5, "first rx after");
		clr();
		u_lk.lvl('{bus_bit: 1, tx_active: 1, default: 0});
		co(5'h2, 5'h2, "first tx bad");
		u_lk.bitx(1'b0, '{tx_err: 1, default: 0});
		co(5'h2, 5'h0, "resend good");
		u_lk.lvl(IDLE);
		acc(1'b1, OFS_CTRL, 32'h4);
		acc(1'b1, OFS_TXREQ, 32'h1);
		co(5'h1C, 5'h0C, "pending");
		u_lk.bitx(1'b1, TXOK);
		rc(OFS_TXEVT, 32'h33, 32'h11, "event type");
		acc(1'b1, OFS_TXREQ, 32'h1);
		rc(OFS_TXREQ, ALL, 32'h0, "early req");
		rc(OFS_STAT, 32'h20, 32'h20, "as lost");
		u_lk.bitx(1'b1, EOF);
		repeat (3) u_lk.bitx(1'b1, '0);
		acc(1'b1, OFS_TXREQ, 32'h1);
		rc(OFS_TXREQ, ALL, 32'h2, "later req");
		u_lk.bitx(1'b1, TXOK);
		acc(1'b1, OFS_CTRL, 32'h0);
		u_lk.lvl(RX);
		u_lk.bitx(1'b1, EOF);
		repeat (2) u_lk.bitx(1'b1, '0);
		acc(1'b1, OFS_TXREQ, 32'h2);
		u_lk.bitx(1'b0, '0);
		co(5'h1E, 5'h16, "unloaded");
		u_lk.bitx(1'b1, TXOK);
		rc(OFS_TXEVT, 32'h33, 32'h21, "logged buf");
		co(5'h2, 5'h0, "corrupt over");
		summarize();
	end
endmodule : cfe_ctrl_test
bind cfe_ctrl cfe_ctrl_checker u_chk (.sys_clk_in, .rst_n_in, .avm_read_in,
	.avm_write_in, .avm_waitrequest_out, .link_in, .tx_corrupt_out,
	.bus_integ_out);
`default_nettype wire
